// ==== logic/rbd_pkg.sv ====
// rbd_pkg: constants for the robot board address decoder.
// assumes a 16-bit multiplexed-address processor bus sampled on clk_sys.
package rbd_pkg;
    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 8;
    localparam int          RAM_ADDR_W      = 15;
    localparam int          SEL_W           = 3;
    localparam int          NUM_SEL         = 8;
    // address bit positions
    localparam int          BIT_RAM         = 15;
    localparam int          BIT_PORT        = 14;
    localparam int          BIT_SEL_HI      = 13;
    localparam int          BIT_SEL_LO      = 12;
    // port block bases (upper nibble), input port and motor latch share 0x7000
    localparam logic [15:0] PORT_BASE_0     = 16'h4000;
    localparam logic [15:0] PORT_BASE_1     = 16'h5000;
    localparam logic [15:0] PORT_BASE_2     = 16'h6000;
    localparam logic [15:0] PORT_BASE_3     = 16'h7000;
    localparam logic [15:0] INPUT_PORT_OFF  = 16'h7000;
    localparam logic [15:0] MOTOR_LATCH_OFF = 16'h7000;
    localparam logic [15:0] RAM_BASE        = 16'h8000;
    // decoder output indices
    localparam logic [2:0]  SEL_EXPANSION   = 3'h0;
    localparam logic [2:0]  SEL_MOTOR       = 3'h6;
    localparam logic [2:0]  SEL_INPUT       = 3'h7;
    // latch contents after reset
    localparam logic [7:0]  LATCH_RESET     = 8'h00;
    localparam logic [7:0]  LOW_ADDR_RESET  = 8'h00;
    localparam logic [7:0]  RD_DATA_RESET   = 8'h00;
    // input byte layout
    localparam int          BUTTON_LSB      = 0;
    localparam int          HEADER_LSB      = 2;
    localparam int          HEADER_W        = 6;
endpackage

// ==== logic/rbd_decoder.sv ====
// rbd_decoder: ram select, 3-to-8 port decoder, input port and output latches.
// assumes a processor bus far slower than clk_sys: every bus pin passes two
// flip-flops, so selects follow the pins two clocks late, and the processor
// must hold address and data steady for several clocks of each phase.
// outputs: selects combinational, latches and read data registered.
// Overview of operation
// R1: ram select needs a15 high and e high
// R2: ram chip enable is active low
// R3: low fifteen address bits address ram
// R4: port decode needs a15 low, a14 high, e
// R5: select value is a13, a12, rw
// R6: rw high reads, low writes
// R7: read in 0x7000 block selects input port
// R8: address bits 0 to 11 ignored
// R9: write in 0x7000 block selects motor latch
// R10: motor latch captures data on select
// R11: select 0 clocks expansion latch; 1-5 spare
// R12: port blocks at 0x4000 through 0x7000
// R13: input select enables all eight bits
// R14: buttons low two bits, header upper six
// R15: unconnected inputs read as one
// R16: latches hold until next selecting write
// R17: processor latches low address before data
`timescale 1ns/10ps
module rbd_decoder #(
    parameter int ADDR_W = rbd_pkg::ADDR_W,
    parameter int DATA_W = rbd_pkg::DATA_W
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_b,
    input  wire logic [ADDR_W-9:0]      addr_high,
    input  wire logic [7:0]             addr_data_in,
    output logic      [7:0]             addr_data_out,
    output logic      [7:0]             addr_data_oe,
    input  wire logic                   addr_strobe,
    input  wire logic                   e_clock,
    input  wire logic                   read_write,
    input  wire logic [1:0]             buttons_in,
    input  wire logic [5:0]             header_in,
    input  wire logic [5:0]             header_connected,
    output logic                        ram_ce_b,
    output logic      [14:0]            ram_addr,
    output logic      [7:0]             port_select,
    output logic                        input_port_select,
    output logic                        motor_latch_select,
    output logic                        expansion_latch_select,
    output logic      [DATA_W-1:0]      motor_control_latch,
    output logic      [DATA_W-1:0]      expansion_latch
);
    // two-stage synchronisers on all pin inputs
    logic [7:0]        ad_s1_reg;
    logic [7:0]        ad_s2_reg;
    logic [ADDR_W-9:0] ah_s1_reg;
    logic [ADDR_W-9:0] ah_s2_reg;
    logic [2:0]        ctl_s1_reg;
    logic [2:0]        ctl_s2_reg;
    logic [7:0]        in_s1_reg;
    logic [7:0]        in_s2_reg;
    logic [5:0]        con_s1_reg;
    logic [5:0]        con_s2_reg;

    // low address capture
    logic [7:0]        low_addr_reg;
    logic [7:0]        low_addr_next;
    logic              as_prev_reg;
    logic              as_prev_next;

    // output latches and select history for edge detection
    logic [DATA_W-1:0] motor_reg;
    logic [DATA_W-1:0] motor_next;
    logic [DATA_W-1:0] exp_reg;
    logic [DATA_W-1:0] exp_next;
    logic              sel_prev_motor_reg;
    logic              sel_prev_motor_next;
    logic              sel_prev_exp_reg;
    logic              sel_prev_exp_next;

    // input port read path
    logic [7:0]        rd_data_reg;
    logic [7:0]        rd_data_next;
    logic              rd_oe_reg;
    logic              rd_oe_next;

    // decode terms
    logic [ADDR_W-1:0] full_addr;
    logic              strobe_s;
    logic              e_s;
    logic              rw_s;
    logic              strobe_fall;
    logic              ram_sel;
    logic              port_en;
    logic [2:0]        sel_code;
    logic [7:0]        sel_vec;
    logic              motor_rise;
    logic              exp_rise;
    logic [5:0]        header_eff;
    logic [7:0]        input_byte;

    // upper half of the map belongs to ram; used by both ram and port gating
    function automatic logic in_ram_half(
        input logic [ADDR_W-1:0] addr
    );
        return addr[rbd_pkg::BIT_RAM];
    endfunction

    // one compare shared by all eight decoder outputs
    function automatic logic sel_match(
        input logic       enable,
        input logic [2:0] code,
        input logic [2:0] index
    );
        return enable && (code == index);
    endfunction

    // pin synchronisers: only the second stage is read by logic
    // multi-bit words are safe only because the processor holds them steady
    always_ff @(posedge clk_sys)
    begin
        ad_s1_reg <= addr_data_in;
        ad_s2_reg <= ad_s1_reg;
    end

    always_ff @(posedge clk_sys)
    begin
        ah_s1_reg <= addr_high;
        ah_s2_reg <= ah_s1_reg;
    end

    always_ff @(posedge clk_sys)
    begin
        ctl_s1_reg <= {addr_strobe, e_clock, read_write};
        ctl_s2_reg <= ctl_s1_reg;
    end

    always_ff @(posedge clk_sys)
    begin
        in_s1_reg <= {header_in, buttons_in};
        in_s2_reg <= in_s1_reg;
    end

    always_ff @(posedge clk_sys)
    begin
        con_s1_reg <= header_connected;
        con_s2_reg <= con_s1_reg;
    end

    assign strobe_s = ctl_s2_reg[2];
    assign e_s      = ctl_s2_reg[1];
    assign rw_s     = ctl_s2_reg[0]; // R6

    // low address taken on falling strobe, before data phase; as_prev resets low
    // to match the idle strobe, so no false edge follows reset
    assign strobe_fall = as_prev_reg && !strobe_s;

    always_comb
    begin
        low_addr_next = low_addr_reg;
        as_prev_next  = strobe_s;
        if (strobe_fall)
        begin
            low_addr_next = ad_s2_reg; // R17
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            low_addr_reg <= rbd_pkg::LOW_ADDR_RESET;
            as_prev_reg  <= 1'b0;
        end
        else
        begin
            low_addr_reg <= low_addr_next;
            as_prev_reg  <= as_prev_next;
        end
    end

    assign full_addr = {ah_s2_reg, low_addr_reg};

    // a15 gating keeps ram and ports mutually exclusive against bus contention
    assign ram_sel  = in_ram_half(full_addr) && e_s; // R1
    assign port_en  = !in_ram_half(full_addr) && full_addr[rbd_pkg::BIT_PORT] && e_s; // R4 R12
    assign sel_code = {full_addr[rbd_pkg::BIT_SEL_HI], full_addr[rbd_pkg::BIT_SEL_LO], rw_s}; // R5 R8

    genvar gi;
    generate
        for (gi = 0; gi < rbd_pkg::NUM_SEL; gi++)
        begin : g_sel
            assign sel_vec[gi] = sel_match(port_en, sel_code, 3'(gi)); // R5
        end
    endgenerate

    // selects lag the pins by the two synchroniser stages
    assign port_select            = sel_vec;             // R11
    assign input_port_select      = sel_vec[rbd_pkg::SEL_INPUT];     // R7
    assign motor_latch_select     = sel_vec[rbd_pkg::SEL_MOTOR];     // R9
    assign expansion_latch_select = sel_vec[rbd_pkg::SEL_EXPANSION]; // R11
    assign ram_ce_b               = !ram_sel;                         // R2
    assign ram_addr               = full_addr[14:0];                  // R3

    // a header line with nothing plugged in floats to its pull-up level
    genvar gh;
    generate
        for (gh = 0; gh < rbd_pkg::HEADER_W; gh++)
        begin : g_pull
            assign header_eff[gh] = con_s2_reg[gh] ? in_s2_reg[rbd_pkg::HEADER_LSB + gh] : 1'b1; // R15
        end
    endgenerate

    always_comb
    begin
        input_byte = 8'hff; // R15
        input_byte[rbd_pkg::BUTTON_LSB +: 2] = in_s2_reg[1:0]; // R14
        input_byte[rbd_pkg::HEADER_LSB +: rbd_pkg::HEADER_W] = header_eff; // R14
    end

    // latches capture on rising select; reads leave them alone
    assign motor_rise = sel_vec[rbd_pkg::SEL_MOTOR] && !sel_prev_motor_reg;
    assign exp_rise   = sel_vec[rbd_pkg::SEL_EXPANSION] && !sel_prev_exp_reg;

    always_comb
    begin
        motor_next          = motor_reg;
        sel_prev_motor_next = sel_vec[rbd_pkg::SEL_MOTOR];
        if (motor_rise)
        begin
            motor_next = ad_s2_reg[DATA_W-1:0]; // R10 R16
        end
    end

    // one capture per select pulse; a long e phase cannot reload the latch
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            motor_reg          <= rbd_pkg::LATCH_RESET;
            sel_prev_motor_reg <= 1'b0;
        end
        else
        begin
            motor_reg          <= motor_next;
            sel_prev_motor_reg <= sel_prev_motor_next;
        end
    end

    // the expansion latch follows the same one-capture scheme
    always_comb
    begin
        exp_next          = exp_reg;
        sel_prev_exp_next = sel_vec[rbd_pkg::SEL_EXPANSION];
        if (exp_rise)
        begin
            exp_next = ad_s2_reg[DATA_W-1:0]; // R11 R16
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            exp_reg          <= rbd_pkg::LATCH_RESET;
            sel_prev_exp_reg <= 1'b0;
        end
        else
        begin
            exp_reg          <= exp_next;
            sel_prev_exp_reg <= sel_prev_exp_next;
        end
    end

    // all eight bits driven together while input select is active
    always_comb
    begin
        rd_data_next = rd_data_reg;
        rd_oe_next   = 1'b0;
        if (sel_vec[rbd_pkg::SEL_INPUT])
        begin
            rd_data_next = input_byte; // R7
            rd_oe_next   = 1'b1;       // R13
        end
    end

    // bus released one clock after the select drops, never earlier
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            rd_data_reg <= rbd_pkg::RD_DATA_RESET;
            rd_oe_reg   <= 1'b0;
        end
        else
        begin
            rd_data_reg <= rd_data_next;
            rd_oe_reg   <= rd_oe_next;
        end
    end

    // registered outputs
    assign motor_control_latch = motor_reg;
    assign expansion_latch     = exp_reg;
    assign addr_data_out       = rd_data_reg;
    assign addr_data_oe        = {8{rd_oe_reg}}; // R13

endmodule // rbd_decoder

// ==== bench/rbd_decoder_asserts.sv ====
// rbd_decoder_asserts: port checks for the decoder.
// assumes bind to rbd_decoder; pins reach selects 2 clocks late.
`timescale 1ns/10ps
module rbd_decoder_asserts (
    input wire logic       clk_sys,
    input wire logic       rst_b,
    input wire logic [7:0] addr_high,
    input wire logic       e_clock,
    input wire logic       ram_ce_b,
    input wire logic [7:0] port_select,
    input wire logic       input_port_select,
    input wire logic       motor_latch_select,
    input wire logic [7:0] addr_data_oe,
    input wire logic [7:0] motor_control_latch,
    input wire logic [7:0] expansion_latch
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // synchroniser delay makes the cause two edges old
    sequence s_port_win;
        $past(e_clock, 2) && !$past(addr_high[7], 2) && $past(addr_high[6], 2);
    endsequence
    a_ram_gate: assert property (!ram_ce_b |-> $past(e_clock, 2) && $past(addr_high[7], 2))
        else $error("ram enable wrong");
    a_port_gate: assert property (|port_select |-> s_port_win)
        else $error("port select wrong");
    a_no_clash: assert property (!(!ram_ce_b && |port_select))
        else $error("ram and port together");
    a_one_hot: assert property ($onehot0(port_select))
        else $error("select not one hot");
    a_motor_hold: assert property ($changed(motor_control_latch) |-> $past(motor_latch_select))
        else $error("motor latch moved");
    a_exp_hold: assert property ($changed(expansion_latch) |-> $past(port_select[0]))
        else $error("expansion latch moved");
    a_oe_follow: assert property ($rose(input_port_select) |=> addr_data_oe == 8'hff)
        else $error("bus not driven");
    a_oe_drop: assert property (|addr_data_oe |-> $past(input_port_select))
        else $error("bus driven late");
endmodule // rbd_decoder_asserts
bind rbd_decoder rbd_decoder_asserts i_rbd_decoder_asserts (.clk_sys(clk_sys), .rst_b(rst_b),
    .addr_high(addr_high), .e_clock(e_clock), .ram_ce_b(ram_ce_b), .port_select(port_select),
    .input_port_select(input_port_select), .motor_latch_select(motor_latch_select), .addr_data_oe(addr_data_oe),
    .motor_control_latch(motor_control_latch), .expansion_latch(expansion_latch));

// ==== bench/rbd_cpu_model.sv ====
// rbd_cpu_model: processor side of the multiplexed bus.
// assumes the bench clock; drives at falling edges only.
`timescale 1ns/10ps
module rbd_cpu_model (
    input wire logic       clk_sys,
    input wire logic [7:0] addr_data_out,
    input wire logic [7:0] addr_data_oe,
    output logic     [7:0] addr_high,
    output logic     [7:0] addr_data_in,
    output logic           addr_strobe,
    output logic           e_clock,
    output logic           read_write
);
    initial
    begin
        {addr_high, addr_data_in, addr_strobe, e_clock, read_write} = 19'h00001;
    end
    task automatic cycle(input logic [15:0] a, input logic rw, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk_sys);
        {addr_high, addr_data_in, addr_strobe, read_write} = {a, 1'b1, rw};
        @(negedge clk_sys);
        addr_strobe = 1'b0;
        repeat (3) @(negedge clk_sys);
        e_clock = 1'b1;
        // released on read: show junk, never the held address
        addr_data_in = rw ? ~a[7:0] : d;
        repeat (5) @(negedge clk_sys);
        q = (addr_data_oe === 8'hff) ? addr_data_out : 8'h00;
        e_clock = 1'b0;
        addr_data_in = ~addr_data_in;
        repeat (3) @(negedge clk_sys);
    endtask
endmodule // rbd_cpu_model

// ==== bench/rbd_decoder_test.sv ====
// rbd_decoder_test: self-checking bench for the decoder.
// assumes rbd_cpu_model as master, checker bound in.
`timescale 1ns/10ps
module rbd_decoder_test;
    logic [7:0]  addr_high, addr_data_in, addr_data_out, addr_data_oe, port_select, seen, q;
    logic [7:0]  motor_control_latch, expansion_latch;
    logic        addr_strobe, e_clock, read_write, ram_ce_b, input_port_select, motor_latch_select, ram_hit;
    logic        expansion_latch_select;
    logic [14:0] ram_addr, ram_seen;
    logic [2:0]  named;
    logic [1:0]  buttons = 2'h2;
    logic [5:0]  header = 6'h2a, header_con = 6'h0f;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    int          n_mismatch = 0;
    int          tests_run = 0;
    always #12.5 clk_sys = ~clk_sys;
    rbd_decoder i_rbd_decoder (.clk_sys(clk_sys), .rst_b(rst_b), .addr_high(addr_high),
        .addr_data_in(addr_data_in), .addr_data_out(addr_data_out), .addr_data_oe(addr_data_oe),
        .addr_strobe(addr_strobe), .e_clock(e_clock), .read_write(read_write), .buttons_in(buttons),
        .header_in(header), .header_connected(header_con), .ram_ce_b(ram_ce_b), .ram_addr(ram_addr),
        .port_select(port_select), .input_port_select(input_port_select), .motor_latch_select(motor_latch_select),
        .expansion_latch_select(expansion_latch_select), .motor_control_latch(motor_control_latch),
        .expansion_latch(expansion_latch));
    rbd_cpu_model i_rbd_cpu_model (.clk_sys(clk_sys), .addr_data_out(addr_data_out), .addr_data_oe(addr_data_oe),
        .addr_high(addr_high), .addr_data_in(addr_data_in), .addr_strobe(addr_strobe), .e_clock(e_clock),
        .read_write(read_write));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus cycle while gathering every select seen during it
    task automatic xfer(input logic [15:0] a, input logic rw, input logic [7:0] d);
        seen = 8'h00;
        named = 3'h0;
        ram_hit = 1'b0;
        fork
            i_rbd_cpu_model.cycle(a, rw, d, q);
            repeat (12) @(posedge clk_sys)
            begin
                #1;
                seen |= port_select;
                named |= {input_port_select, motor_latch_select, expansion_latch_select};
                ram_hit |= !ram_ce_b;
                ram_seen = ram_ce_b ? ram_seen : ram_addr;
            end
        join
    endtask
    task automatic t_ram;
        xfer(16'h8000, 1'b1, 8'h00);
        chk({7'h00, ram_hit, seen}, 16'h0100);
        chk({1'b0, ram_seen}, 16'h0000);
        xfer(16'hffff, 1'b0, 8'h11);
        chk({7'h00, ram_hit, seen}, 16'h0100);
        chk({1'b0, ram_seen}, 16'h7fff);
    endtask
    // low address bits flip with rw to show they are ignored
    task automatic t_ports;
        for (int k = 4; k < 16; k++)
        begin
            xfer({1'b0, k[3:1], {12{k[0]}}}, k[0], 8'h00);
            chk({7'h00, ram_hit, seen}, k < 8 ? 16'h0000 : 16'h0001 << k[2:0]);
            chk({13'h0000, named}, k == 15 ? 16'h0004 : k == 14 ? 16'h0002 : k == 8 ? 16'h0001 : 16'h0000);
        end
    endtask
    task automatic t_latches;
        xfer(16'h7abc, 1'b0, 8'ha5);
        chk({8'h00, motor_control_latch}, 16'h00a5);
        xfer(16'h7000, 1'b1, 8'h00);
        chk({q, motor_control_latch}, 16'heaa5);
        buttons = 2'h1;
        header = 6'h15;
        header_con = 6'h3f;
        xfer(16'h7fff, 1'b1, 8'h00);
        chk({q, motor_control_latch}, 16'h55a5);
        xfer(16'h4123, 1'b0, 8'h3c);
        chk({expansion_latch, motor_control_latch}, 16'h3ca5);
    endtask
    task automatic summarize;
        if (n_mismatch == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (3) @(negedge clk_sys);
        t_ram;
        t_ports;
        t_latches;
        summarize;
    end
endmodule // rbd_decoder_test
